// >>> hdl/source_fsm_pkg.sv
// Purpose: Shared constants, types and lookups for the reverse-power output controller.
// Assumes: 250 MHz system clock; register index times four gives the byte address.
// Notes:   Millisecond timers count a 1 ms tick built from the system clock.
package source_fsm_pkg;

  // ----------------------------------------------------------------
  // Register indices and field positions
  // ----------------------------------------------------------------
  localparam int           ADDR_W           = 8;
  localparam logic [5:0]   IDX_WDOG         = 6'h00;
  localparam logic [5:0]   IDX_MODE         = 6'h01;
  localparam logic [5:0]   IDX_OUTCFG       = 6'h0E;
  localparam logic [5:0]   IDX_ENCFG        = 6'h0F;
  localparam logic [5:0]   IDX_MASK         = 6'h10;
  localparam logic [5:0]   IDX_STATUS       = 6'h11;
  localparam int           WDOG_RESTART_BIT = 0;
  localparam int           WDOG_PER_LSB     = 1;
  localparam int           MODE_HIZ_BIT     = 0;
  localparam int           MODE_OC16_BIT    = 1;
  localparam int           OUTCFG_SS_BIT    = 0;
  localparam int           OUTCFG_LL_LSB    = 1;
  localparam int           ENCFG_DLY_LSB    = 0;
  localparam int           ENCFG_EN_BIT     = 2;
  localparam int           MASK_REGFLT_BIT  = 1;
  localparam logic [7:0]   RST_BYTE         = 8'h00;
  localparam logic [1:0]   RESP_OKAY        = 2'b00;
  localparam logic [1:0]   RESP_SLVERR      = 2'b10;

  // ----------------------------------------------------------------
  // Times and counts
  // ----------------------------------------------------------------
  localparam int           CLK_MHZ          = 250;
  localparam int           TICK_US          = 1000;
  localparam int           TICK_CYCLES      = TICK_US * CLK_MHZ;
  localparam logic [17:0]  REGFLT_HOLD_MS   = 18'h0_0064;
  localparam logic [17:0]  HICCUP_MS        = 18'h0_0BB8;
  localparam logic [17:0]  SS_FAST_MS       = 18'h0_0002;
  localparam logic [17:0]  SS_SLOW_MS       = 18'h0_0008;
  localparam logic [4:0]   OC_CYCLES_LOW    = 5'h08;
  localparam logic [4:0]   OC_CYCLES_HIGH   = 5'h10;

  typedef enum logic [2:0] {
    source_reset_wait_state     = 3'b000,
    source_soft_start_state     = 3'b001,
    source_regulation_state     = 3'b011,
    source_light_load_off_state = 3'b010,
    source_hiccup_state         = 3'b110
  } state_e;

  // ----------------------------------------------------------------
  // Lookups
  // ----------------------------------------------------------------
  function automatic logic [17:0] enable_delay_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    enable_delay_ms = 18'h0_0001;
      2'h1:    enable_delay_ms = 18'h0_0004;
      2'h2:    enable_delay_ms = 18'h0_0010;
      default: enable_delay_ms = 18'h0_0040;
    endcase
  endfunction

  function automatic logic [17:0] light_load_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    light_load_ms = 18'h0_03E8;
      2'h1:    light_load_ms = 18'h0_1388;
      2'h2:    light_load_ms = 18'h0_2710;
      default: light_load_ms = 18'h0_4E20;
    endcase
  endfunction

  function automatic logic [17:0] watchdog_ms(input logic [1:0] sel);
    case (sel)
      2'h1:    watchdog_ms = 18'h0_9C40;
      2'h2:    watchdog_ms = 18'h1_3880;
      default: watchdog_ms = 18'h2_7100;
    endcase
  endfunction

endpackage

// >>> hdl/source_output_ctrl.sv
// Purpose: Reverse-power output sequencer with fault qualification and AXI4-Lite registers.
// Assumes: All status inputs are synchronous to CLK_I; comparators live in the analog part.
// Notes:   Timers restart on every state entry, so their first tick may come early by < 1 ms.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// R1 - Each session starts in reset/wait with converter off until blocking faults clear.
// R2 - With faults clear, run selectable enable delay, then enter soft start.
// R3 - Battery below cutoff level blocks start; clears when battery rises above it.
// R4 - Regulator fault plus 100 ms hold blocks start unless the mask bit is set.
// R5 - Thermistor hot or cold blocks start; clears when temperature is back in range.
// R6 - Expired enabled watchdog blocks; host clears it by writing restart bit.
// R7 - Writing zero watchdog period also clears the watchdog fault.
// R8 - In reset/wait both charging safety timers are held at their count.
// R9 - 8 or 16 overcurrent cycles latch a fault, cleared only on mode exit.
// R10 - Battery overvoltage blocks while above threshold, clears when below.
// R11 - Die overtemperature holds until cooled by hysteresis; no mask or clear.
// R12 - Soft start enables converter for a time chosen by a configuration bit.
// R13 - Any fault during soft start returns to reset with converter off.
// R14 - Soft start done with output in regulation moves to regulation.
// R15 - Major fault in regulation returns to reset and turns converter off.
// R16 - Output below 3.0 V in regulation enters hiccup.
// R17 - Light load beyond selected timeout enters light-load off, switching stops.
// R18 - Light-load off entered only in buck topology.
// R19 - Light-load off left only when output mode is exited.
// R20 - Hiccup keeps converter off 3 s then returns to reset.
// R21 - Output mode needs active-low enable pin and the enable configuration bit.
// R22 - Millisecond timers count an internal tick and restart on state entry.
module source_output_ctrl
  import source_fsm_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              CLK_I,
  input  wire logic              RESET_N_I,
  // AXI4-Lite write channels
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  input  wire logic [31:0]       S_AXI_WDATA_I,
  input  wire logic [3:0]        S_AXI_WSTRB_I,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  output logic [1:0]             S_AXI_BRESP_O,
  // AXI4-Lite read channels
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  output logic [31:0]            S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  // Enable pin and analog status
  input  wire logic              SOURCE_ENABLE_PIN_N_I,
  input  wire logic              BATTERY_BELOW_CUTOFF_I,
  input  wire logic              AUX_REGULATOR_FAULT_I,
  input  wire logic              THERMISTOR_HOT_I,
  input  wire logic              THERMISTOR_COLD_I,
  input  wire logic              BATTERY_OVERVOLTAGE_I,
  input  wire logic              DIE_ABOVE_SHUTDOWN_I,
  input  wire logic              DIE_COOLED_I,
  input  wire logic              SWITCH_CYCLE_END_I,
  input  wire logic              SWITCH_CYCLE_OVERCURRENT_I,
  input  wire logic              OUTPUT_IN_REGULATION_I,
  input  wire logic              OUTPUT_UNDERVOLTAGE_I,
  input  wire logic              LIGHT_LOAD_I,
  input  wire logic              TOPOLOGY_BUCK_I,
  // Converter control
  output logic                   CONVERTER_EN_O,
  output logic                   SOFT_START_TIME_SEL_O,
  output logic                   SAFETY_TIMER_HOLD_O,
  output logic [2:0]             STATE_O
);

  // ----------------------------------------------------------------
  // Reset synchroniser and millisecond tick
  // ----------------------------------------------------------------
  logic        rst_meta_reg;
  logic        rst_n;
  logic [17:0] tick_cnt_reg;
  logic        tick;

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  assign tick = (tick_cnt_reg == 18'(TICK_CYC - 1));

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt_reg <= 18'h0_0000;
    end else begin
      tick_cnt_reg <= tick ? 18'h0_0000 : tick_cnt_reg + 18'h0_0001; // see R22
    end
  end

  // ----------------------------------------------------------------
  // Registers and AXI4-Lite slave
  // ----------------------------------------------------------------
  logic [1:0]  wdog_per_reg;
  logic        wdog_restart;
  logic        hiz_reg;
  logic        oc16_reg;
  logic        ss_sel_reg;
  logic [1:0]  ll_sel_reg;
  logic [1:0]  dly_sel_reg;
  logic        en_cfg_reg;
  logic        regflt_mask_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [5:0]  aw_idx_reg;
  logic [7:0]  wbyte_reg;
  logic        wlane_reg;
  logic        do_write;
  logic [7:0]  status_byte;
  logic [7:0]  rd_byte;
  logic        rd_hit;
  state_e      state_reg;
  state_e      state_next;
  logic [7:0]  fault_vec;

  assign S_AXI_AWREADY_O = !aw_held_reg;
  assign S_AXI_WREADY_O  = !w_held_reg;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;
  assign do_write        = aw_held_reg && w_held_reg && !S_AXI_BVALID_O;
  assign wdog_restart    = do_write && wlane_reg && (aw_idx_reg == IDX_WDOG)
                           && wbyte_reg[WDOG_RESTART_BIT];

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg    <= 1'b0;
      w_held_reg     <= 1'b0;
      aw_idx_reg     <= 6'h00;
      wbyte_reg      <= RST_BYTE;
      wlane_reg      <= 1'b0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID_I && !aw_held_reg) begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= S_AXI_AWADDR_I[7:2];
      end
      if (S_AXI_WVALID_I && !w_held_reg) begin
        w_held_reg <= 1'b1;
        wbyte_reg  <= S_AXI_WDATA_I[7:0];
        wlane_reg  <= S_AXI_WSTRB_I[0];
      end
      if (do_write) begin
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O  <= (aw_idx_reg == IDX_WDOG || aw_idx_reg == IDX_MODE
                           || aw_idx_reg == IDX_OUTCFG || aw_idx_reg == IDX_ENCFG
                           || aw_idx_reg == IDX_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
        aw_held_reg    <= 1'b0;
        w_held_reg     <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wdog_per_reg    <= 2'b00;
      hiz_reg         <= 1'b0;
      oc16_reg        <= 1'b0;
      ss_sel_reg      <= 1'b0;
      ll_sel_reg      <= 2'b00;
      dly_sel_reg     <= 2'b00;
      en_cfg_reg      <= 1'b0;
      regflt_mask_reg <= 1'b0;
    end else if (do_write && wlane_reg) begin
      case (aw_idx_reg)
        IDX_WDOG: begin
          wdog_per_reg <= wbyte_reg[WDOG_PER_LSB +: 2];
        end
        IDX_MODE: begin
          hiz_reg  <= wbyte_reg[MODE_HIZ_BIT];
          oc16_reg <= wbyte_reg[MODE_OC16_BIT];
        end
        IDX_OUTCFG: begin
          ss_sel_reg <= wbyte_reg[OUTCFG_SS_BIT];
          ll_sel_reg <= wbyte_reg[OUTCFG_LL_LSB +: 2];
        end
        IDX_ENCFG: begin
          dly_sel_reg <= wbyte_reg[ENCFG_DLY_LSB +: 2];
          en_cfg_reg  <= wbyte_reg[ENCFG_EN_BIT];
        end
        IDX_MASK: begin
          regflt_mask_reg <= wbyte_reg[MASK_REGFLT_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  assign status_byte = {5'h00, state_reg};

  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = RST_BYTE;
    case (S_AXI_ARADDR_I[7:2])
      IDX_WDOG:   rd_byte = {5'h00, wdog_per_reg, 1'b0};
      IDX_MODE:   rd_byte = {6'h00, oc16_reg, hiz_reg};
      IDX_OUTCFG: rd_byte = {5'h00, ll_sel_reg, ss_sel_reg};
      IDX_ENCFG:  rd_byte = {5'h00, en_cfg_reg, dly_sel_reg};
      IDX_MASK:   rd_byte = {6'h00, regflt_mask_reg, 1'b0};
      IDX_STATUS: rd_byte = status_byte;
      default:    rd_hit  = 1'b0;
    endcase
  end

  // The fault vector sits in byte 1 of the status word.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O  <= 32'h0000_0000;
      S_AXI_RRESP_O  <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && !S_AXI_RVALID_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RDATA_O  <= {16'h0000,
                         (S_AXI_ARADDR_I[7:2] == IDX_STATUS) ? fault_vec : 8'h00, rd_byte};
      S_AXI_RRESP_O  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Fault qualification
  // ----------------------------------------------------------------
  logic        mode_active;
  logic [17:0] regflt_hold_reg;
  logic        regflt;
  logic [17:0] wdog_cnt_reg;
  logic        wdog_fault_reg;
  logic [4:0]  oc_run_reg;
  logic        oc_fault_reg;
  logic        die_fault_reg;
  logic        blocking;

  assign mode_active = en_cfg_reg && !SOURCE_ENABLE_PIN_N_I && !hiz_reg; // see R21
  assign regflt      = AUX_REGULATOR_FAULT_I || (regflt_hold_reg < REGFLT_HOLD_MS);

  // The regulator fault is held for its timeout after the raw fault drops.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      regflt_hold_reg <= REGFLT_HOLD_MS;
    end else if (AUX_REGULATOR_FAULT_I) begin
      regflt_hold_reg <= 18'h0_0000; // see R4
    end else if (tick && regflt_hold_reg < REGFLT_HOLD_MS) begin
      regflt_hold_reg <= regflt_hold_reg + 18'h0_0001;
    end
  end

  // Expiry outranks restart so that a timeout in the restart cycle is not lost.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      wdog_cnt_reg   <= 18'h0_0000;
      wdog_fault_reg <= 1'b0;
    end else if (wdog_per_reg == 2'b00) begin
      wdog_cnt_reg   <= 18'h0_0000;
      wdog_fault_reg <= 1'b0; // see R7
    end else if (tick && wdog_cnt_reg + 18'h0_0001 >= watchdog_ms(wdog_per_reg)) begin
      wdog_cnt_reg   <= 18'h0_0000;
      wdog_fault_reg <= 1'b1; // see R6
    end else if (wdog_restart) begin
      wdog_cnt_reg   <= 18'h0_0000;
      wdog_fault_reg <= 1'b0; // see R6
    end else if (tick) begin
      wdog_cnt_reg   <= wdog_cnt_reg + 18'h0_0001;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      oc_run_reg   <= 5'h00;
      oc_fault_reg <= 1'b0;
    end else begin
      if (SWITCH_CYCLE_END_I) begin
        oc_run_reg <= SWITCH_CYCLE_OVERCURRENT_I ? oc_run_reg + 5'h01 : 5'h00;
      end
      if (SWITCH_CYCLE_END_I && SWITCH_CYCLE_OVERCURRENT_I
          && oc_run_reg + 5'h01 >= (oc16_reg ? OC_CYCLES_HIGH : OC_CYCLES_LOW)) begin
        oc_fault_reg <= 1'b1; // see R9
        oc_run_reg   <= 5'h00;
      end else if (!mode_active) begin
        oc_fault_reg <= 1'b0; // see R9
      end
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      die_fault_reg <= 1'b0;
    end else if (DIE_ABOVE_SHUTDOWN_I) begin
      die_fault_reg <= 1'b1; // see R11
    end else if (DIE_COOLED_I) begin
      die_fault_reg <= 1'b0; // see R11
    end
  end

  assign fault_vec = {BATTERY_BELOW_CUTOFF_I, regflt, THERMISTOR_HOT_I, THERMISTOR_COLD_I,
                      wdog_fault_reg, oc_fault_reg, BATTERY_OVERVOLTAGE_I, die_fault_reg};
  assign blocking  = BATTERY_BELOW_CUTOFF_I                 // see R3
                     || (regflt && !regflt_mask_reg)        // see R4
                     || THERMISTOR_HOT_I || THERMISTOR_COLD_I // see R5
                     || wdog_fault_reg || oc_fault_reg
                     || BATTERY_OVERVOLTAGE_I               // see R10
                     || die_fault_reg;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [17:0] timer_ms_reg;
  logic [17:0] ll_ms_reg;
  logic        timer_restart;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      source_reset_wait_state: begin
        if (mode_active && !blocking && timer_ms_reg >= enable_delay_ms(dly_sel_reg)) begin
          state_next = source_soft_start_state; // see R1, R2
        end
      end
      source_soft_start_state: begin
        if (blocking || !mode_active) begin
          state_next = source_reset_wait_state; // see R13
        end else if (timer_ms_reg >= (ss_sel_reg ? SS_SLOW_MS : SS_FAST_MS)
                     && OUTPUT_IN_REGULATION_I) begin
          state_next = source_regulation_state; // see R12, R14
        end
      end
      source_regulation_state: begin
        if (blocking || !mode_active) begin
          state_next = source_reset_wait_state; // see R15
        end else if (OUTPUT_UNDERVOLTAGE_I) begin
          state_next = source_hiccup_state; // see R16
        end else if (TOPOLOGY_BUCK_I && LIGHT_LOAD_I
                     && ll_ms_reg >= light_load_ms(ll_sel_reg)) begin
          // The live topology is checked too, as the counter clears one cycle late.
          state_next = source_light_load_off_state; // see R17, R18
        end
      end
      source_light_load_off_state: begin
        if (!mode_active) begin
          state_next = source_reset_wait_state; // see R19
        end
      end
      source_hiccup_state: begin
        if (timer_ms_reg >= HICCUP_MS) begin
          state_next = source_reset_wait_state; // see R20
        end
      end
      default: state_next = source_reset_wait_state;
    endcase
  end

  assign timer_restart = (state_next != state_reg)
                         || (state_reg == source_reset_wait_state && (blocking || !mode_active));

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= source_reset_wait_state;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      timer_ms_reg <= 18'h0_0000;
    end else if (timer_restart) begin
      timer_ms_reg <= 18'h0_0000; // see R22
    end else if (tick && timer_ms_reg != 18'h3_FFFF) begin
      timer_ms_reg <= timer_ms_reg + 18'h0_0001;
    end
  end

  // Light load only counts in buck topology, so other topologies never time out.
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      ll_ms_reg <= 18'h0_0000;
    end else if (state_reg != source_regulation_state || !LIGHT_LOAD_I || !TOPOLOGY_BUCK_I) begin
      ll_ms_reg <= 18'h0_0000; // see R18
    end else if (tick && ll_ms_reg != 18'h3_FFFF) begin
      ll_ms_reg <= ll_ms_reg + 18'h0_0001;
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CONVERTER_EN_O        <= 1'b0;
      SOFT_START_TIME_SEL_O <= 1'b0;
      SAFETY_TIMER_HOLD_O   <= 1'b1;
      STATE_O               <= 3'b000;
    end else begin
      CONVERTER_EN_O        <= (state_next == source_soft_start_state)
                               || (state_next == source_regulation_state); // see R12
      SOFT_START_TIME_SEL_O <= ss_sel_reg;
      SAFETY_TIMER_HOLD_O   <= (state_next == source_reset_wait_state); // see R8
      STATE_O               <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  property p_reset_off;
    state_reg == source_reset_wait_state |-> !CONVERTER_EN_O || $past(state_reg) != state_reg;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("converter on in reset"); // see R1

  property p_start_needs_delay;
    state_reg == source_reset_wait_state && state_next == source_soft_start_state
      |-> !blocking && timer_ms_reg >= enable_delay_ms(dly_sel_reg);
  endproperty
  a_start_needs_delay: assert property (p_start_needs_delay)
    else $error("soft start before delay"); // see R2

  property p_ss_fault;
    state_reg == source_soft_start_state && blocking
      |=> state_reg == source_reset_wait_state ##1 !CONVERTER_EN_O;
  endproperty
  a_ss_fault: assert property (p_ss_fault) else $error("fault in soft start kept"); // see R13

  property p_reg_uv;
    state_reg == source_regulation_state && !blocking && mode_active && OUTPUT_UNDERVOLTAGE_I
      |=> state_reg == source_hiccup_state;
  endproperty
  a_reg_uv: assert property (p_reg_uv) else $error("no hiccup on undervoltage"); // see R16

  property p_ll_buck;
    state_reg != source_light_load_off_state ##1 state_reg == source_light_load_off_state
      |-> $past(TOPOLOGY_BUCK_I);
  endproperty
  a_ll_buck: assert property (p_ll_buck) else $error("light-load off outside buck"); // see R18

  property p_ll_stays;
    state_reg == source_light_load_off_state && mode_active
      |=> state_reg == source_light_load_off_state;
  endproperty
  a_ll_stays: assert property (p_ll_stays) else $error("light-load off left early"); // see R19

  property p_oc_latch;
    oc_fault_reg && mode_active |=> oc_fault_reg;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent latch lost"); // see R9

  property p_die_hold;
    die_fault_reg && !DIE_COOLED_I |=> die_fault_reg;
  endproperty
  a_die_hold: assert property (p_die_hold) else $error("die fault released hot"); // see R11

  property p_wdog_off;
    wdog_per_reg == 2'b00 |=> !wdog_fault_reg || wdog_per_reg != 2'b00;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("watchdog fault survives disable"); // see R7

  property p_hold_tracks;
    ##1 SAFETY_TIMER_HOLD_O == (state_reg == source_reset_wait_state);
  endproperty
  a_hold_tracks: assert property (p_hold_tracks) else $error("safety hold mismatch"); // see R8

endmodule

`default_nettype wire

// >>> dv/host_pin_model.sv
// Purpose: Host side model that drives the output-mode request pin.
// Assumes: The request pin is active low and idles high.
// Notes:   Level only; no timing of its own.
`timescale 1ns/100ps
`default_nettype none
module host_pin_model (
  // Host request
  input  wire logic req_i,
  // Pin
  output logic      pin_n_o
);
  assign pin_n_o = !req_i;
endmodule
`default_nettype wire

// >>> dv/source_output_ctrl_test.sv
// Purpose: Self-checking bench for the output sequencer.
// Assumes: A short tick keeps the 3 s hiccup within the run.
// Notes:   Expected states and read words wait in queues for the monitor.
`timescale 1ns/100ps
`default_nettype none
module source_output_ctrl_test;
  import source_fsm_pkg::*;
  localparam int TK = 10;
  logic CLK_I, RESET_N_I, awv, wv, bry, arv, rry, req, pin_n, uv, buck;
  logic awr, wr_o, bv, arr, rv, en, sel, hold;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0] br, rr;
  logic [2:0] st, last_st;
  logic [3:0] flt;
  logic regf, dhot, dcool, ce, oc, ll, rnd, ssx;
  logic [33:0] sq[$], rq[$], bq[$];
  int mismatches, total_checks, seed;
  host_pin_model u_host_pin_model (.req_i(req), .pin_n_o(pin_n));
  source_output_ctrl #(.TICK_CYC(TK)) u_source_output_ctrl (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_AWADDR_I(awa), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_o), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hF), .S_AXI_BVALID_O(bv),
    .S_AXI_BREADY_I(bry), .S_AXI_BRESP_O(br), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_ARADDR_I(ara), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rry), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rr), .SOURCE_ENABLE_PIN_N_I(pin_n), .BATTERY_BELOW_CUTOFF_I(flt[0]),
    .AUX_REGULATOR_FAULT_I(regf), .THERMISTOR_HOT_I(flt[1]), .THERMISTOR_COLD_I(flt[2]),
    .BATTERY_OVERVOLTAGE_I(flt[3]), .DIE_ABOVE_SHUTDOWN_I(dhot), .DIE_COOLED_I(dcool),
    .SWITCH_CYCLE_END_I(ce), .SWITCH_CYCLE_OVERCURRENT_I(oc), .OUTPUT_IN_REGULATION_I(1'b1),
    .OUTPUT_UNDERVOLTAGE_I(uv), .LIGHT_LOAD_I(ll), .TOPOLOGY_BUCK_I(buck),
    .CONVERTER_EN_O(en), .SOFT_START_TIME_SEL_O(sel), .SAFETY_TIMER_HOLD_O(hold), .STATE_O(st));
  initial begin
    CLK_I = 0;
    forever #2 CLK_I = ~CLK_I;
  end
  task chk(input logic [33:0] e, input logic [33:0] s);
    total_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value state_or_read expected %h seen %h", e, s);
    end
  endtask
  always @(posedge CLK_I) begin
    buck <= rnd ? 1'($random(seed)) : 1'b1;
    if (RESET_N_I === 1'b1 && st !== last_st) begin
      chk(sq.size() ? sq.pop_front() : 34'h3_FFFF_FFFF, {31'h0, st});
      last_st <= st;
    end
    if (RESET_N_I === 1'b1) begin
      chk({31'h0, st == 3'b001 || st == 3'b011, st == 3'b000, ssx},
          {31'h0, en, hold, sel});
    end
    if (rv === 1'b1 && rry === 1'b1) chk(rq.size() ? rq.pop_front() : 34'h3_FFFF_FFFF, {rr, rdat});
    if (bv === 1'b1 && bry === 1'b1) chk(bq.size() ? bq.pop_front() : 34'h3_FFFF_FFFF, {32'h0, br});
  end
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic pa, pw;
    bq.push_back({32'h0, e});
    pa = 1;
    pw = 1;
    awv <= 1; wv <= 1; awa <= a; wd <= d;
    while (pa || pw) begin
      @(posedge CLK_I);
      if (pa && awr === 1'b1) begin pa = 0; awv <= 0; end
      if (pw && wr_o === 1'b1) begin pw = 0; wv <= 0; end
    end
    bry <= 1;
    do @(posedge CLK_I); while (bv !== 1'b1);
    bry <= 0;
  endtask
  task rd(input logic [7:0] a);
    arv <= 1; ara <= a;
    do @(posedge CLK_I); while (arr !== 1'b1);
    arv <= 0; rry <= 1;
    do @(posedge CLK_I); while (rv !== 1'b1);
    rry <= 0;
  endtask
  task w8(input logic [2:0] v, input int n);
    int k;
    k = 0;
    while (st !== v && k < n) begin @(posedge CLK_I); k++; end
    if (k >= n) mismatches++;
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    seed = 32'hfcf4f86b; mismatches = 0; total_checks = 0; last_st = 3'b000;
    {awv, wv, bry, arv, rry, req, uv, regf, dhot, ce, oc, ll, ssx} = 0; dcool = 1; rnd = 1;
    flt = 0; awa = 0; ara = 0; wd = 0;
    RESET_N_I = 0;
    repeat (6) @(posedge CLK_I);
    RESET_N_I <= 1;
    repeat (3) @(posedge CLK_I);
    rq.push_back(34'h0); rd({IDX_ENCFG, 2'b00});
    rq.push_back({RESP_SLVERR, 32'h0}); rd(8'hFC); // Unmapped place reads zero.
    wr(8'hFC, 32'h5, RESP_SLVERR);
    sq.push_back(1); sq.push_back(3);
    wr({IDX_ENCFG, 2'b00}, {$random(seed)} & 32'hFFFF_FF00 | 32'h4, RESP_OKAY);
    wr({IDX_OUTCFG, 2'b00}, 32'h1, RESP_OKAY); ssx <= 1;
    req <= 1;
    w8(3'b011, 300);
    for (int f = 0; f < 4; f++) begin
      sq.push_back(0); sq.push_back(1); sq.push_back(3);
      flt[f] <= 1;
      w8(3'b000, 50); flt[f] <= 0; w8(3'b011, 300);
    end
    sq.push_back(6); sq.push_back(0); sq.push_back(1); sq.push_back(3);
    uv <= 1; w8(3'b110, 50); uv <= 0;
    w8(3'b011, 3000 * TK + 600);
    rq.push_back({RESP_OKAY, 32'h3}); rd({IDX_STATUS, 2'b00});
    sq.push_back(0); sq.push_back(1); sq.push_back(3);
    regf <= 1; w8(3'b000, 50); regf <= 0; w8(3'b011, 100 * TK + 300);
    wr({IDX_MASK, 2'b00}, 32'h2, RESP_OKAY); regf <= 1;
    rq.push_back({RESP_OKAY, 32'h4003}); rd({IDX_STATUS, 2'b00}); regf <= 0;
    sq.push_back(0); sq.push_back(1); sq.push_back(3);
    dhot <= 1; dcool <= 0; w8(3'b000, 50); dhot <= 0;
    repeat (30) @(posedge CLK_I);
    dcool <= 1; w8(3'b011, 300);
    sq.push_back(0); sq.push_back(1); sq.push_back(3);
    oc <= 1; ce <= 1; repeat (8) @(posedge CLK_I);
    oc <= 0; ce <= 0; w8(3'b000, 50); repeat (30) @(posedge CLK_I);
    req <= 0; repeat (2) @(posedge CLK_I);
    req <= 1; w8(3'b011, 300);
    ll <= 1; repeat (11000) @(posedge CLK_I);
    sq.push_back(2); rnd <= 0; w8(3'b010, 1000 * TK + 100);
    flt[0] <= 1; repeat (20) @(posedge CLK_I); flt[0] <= 0;
    sq.push_back(0); req <= 0; w8(3'b000, 50);
    @(posedge CLK_I);
    if (sq.size() + rq.size() + bq.size() != 0) mismatches++;
    tally_and_finish;
  end
  initial begin
    #400000;
    mismatches++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
